// file: shared/bid_pkg.sv
// Constants, register map and operation codes for the instruction core.
// Assumes a single pclk domain and an APB register slave.
package bid_pkg;

  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 7;
  localparam int PC_W    = 9;
  localparam int STACK_D = 2;
  // Clock periods per instruction cycle
  localparam int QCYC    = 4;
  localparam logic [1:0] QPH_LAST = 2'(QCYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] REG_INSTR  = 12'h000;
  localparam logic [11:0] REG_ACC    = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_PC     = 12'h00C;
  localparam logic [11:0] REG_AUX    = 12'h010;
  localparam logic [2:0]  FILE_WIN   = 3'h1;

  localparam int STB_C    = 0;
  localparam int STB_DC   = 1;
  localparam int STB_Z    = 2;
  localparam int STB_PD   = 3;
  localparam int STB_TO   = 4;
  localparam int STB_BUSY = 5;
  localparam int STB_STBY = 6;
  localparam int STB_WAKE = 7;

  localparam logic [6:0] TMR_ADDR     = 7'h01;
  localparam logic [6:0] PCL_ADDR     = 7'h02;
  localparam logic [2:0] PORT_DIR_SEL = 3'h6;
  localparam int         OPT_PSA      = 3;

  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] OPT_RST  = 8'hFF;
  localparam logic [7:0] PDIR_RST = 8'hFF;
  localparam logic [8:0] PC_RST   = 9'h000;
  localparam logic [2:0] BANK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [5:0] {
    OP_NOP, OP_STORE_ACC, OP_ZERO_ACC, OP_ZERO_FILE, OP_SUB, OP_DEC,
    OP_OR, OP_AND, OP_XOR, OP_ADD, OP_MOVE, OP_INV, OP_INC, OP_DECSZ,
    OP_RR, OP_RL, OP_SWAP, OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS,
    OP_OPTION, OP_SLEEP, OP_WDT, OP_PORTDIR, OP_BANK, OP_RETURN_WITH_LITERAL, OP_CALL,
    OP_GOTO, OP_LIT_MOV, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR
  } bid_op_t;

endpackage : bid_pkg

// file: src/bid_decode.sv
// Combinational split of a 12-bit instruction word into operation and fields.
// Assumes the word is stable while the core executes it.
`timescale 1ns/10ps
module bid_decode
  import bid_pkg::*;
(
  input  wire logic [11:0] instr,
  output bid_op_t          op,
  output logic [4:0]       fsel,
  output logic [2:0]       bpos,
  output logic [8:0]       lit,
  output logic             wr_acc,
  output logic             wr_file,
  output logic             upd_c,
  output logic             upd_dc,
  output logic             upd_z
);

  logic byte_d;

  assign fsel = instr[4:0];
  assign bpos = instr[7:5];
  assign lit  = instr[8:0];

  // Wildcards drop the loose bits from the match
  always_comb begin
    casez (instr)
      12'b0000_0000_0000: op = OP_NOP;
      12'b0000_0000_0010: op = OP_OPTION;
      12'b0000_0000_0011: op = OP_SLEEP;
      12'b0000_0000_0100: op = OP_WDT;
      12'b0000_0000_0???: op = OP_PORTDIR;
      12'b0000_0001_0???: op = OP_BANK;
      12'b0000_001?_????: op = OP_STORE_ACC;
      12'b0000_010?_????: op = OP_ZERO_ACC;
      12'b0000_011?_????: op = OP_ZERO_FILE;
      12'b0000_10??_????: op = OP_SUB;
      12'b0000_11??_????: op = OP_DEC;
      12'b0001_00??_????: op = OP_OR;
      12'b0001_01??_????: op = OP_AND;
      12'b0001_10??_????: op = OP_XOR;
      12'b0001_11??_????: op = OP_ADD;
      12'b0010_00??_????: op = OP_MOVE;
      12'b0010_01??_????: op = OP_INV;
      12'b0010_10??_????: op = OP_INC;
      12'b0010_11??_????: op = OP_DECSZ;
      12'b0011_00??_????: op = OP_RR;
      12'b0011_01??_????: op = OP_RL;
      12'b0011_10??_????: op = OP_SWAP;
      12'b0011_11??_????: op = OP_INCSZ;
      12'b0100_????_????: op = OP_BCLR;
      12'b0101_????_????: op = OP_BSET;
      12'b0110_????_????: op = OP_BTSC;
      12'b0111_????_????: op = OP_BTSS;
      12'b1000_????_????: op = OP_RETURN_WITH_LITERAL;
      12'b1001_????_????: op = OP_CALL;
      12'b101?_????_????: op = OP_GOTO;
      12'b1100_????_????: op = OP_LIT_MOV;
      12'b1101_????_????: op = OP_LIT_OR;
      12'b1110_????_????: op = OP_LIT_AND;
      12'b1111_????_????: op = OP_LIT_XOR;
      default:            op = OP_NOP;
    endcase
  end

  assign byte_d = op inside {OP_SUB, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_ADD,
                             OP_MOVE, OP_INV, OP_INC, OP_DECSZ, OP_RR,
                             OP_RL, OP_SWAP, OP_INCSZ};
  assign wr_file = (byte_d && instr[5]) ||
                   op inside {OP_STORE_ACC, OP_ZERO_FILE, OP_BCLR, OP_BSET};
  assign wr_acc  = (byte_d && !instr[5]) ||
                   op inside {OP_ZERO_ACC, OP_RETURN_WITH_LITERAL, OP_LIT_MOV, OP_LIT_OR,
                              OP_LIT_AND, OP_LIT_XOR};
  assign upd_c   = op inside {OP_ADD, OP_SUB, OP_RL, OP_RR};
  assign upd_dc  = op inside {OP_ADD, OP_SUB};
  assign upd_z   = op inside {OP_ADD, OP_SUB, OP_ZERO_ACC, OP_ZERO_FILE,
                              OP_INV, OP_DEC, OP_INC, OP_MOVE, OP_OR,
                              OP_AND, OP_XOR, OP_LIT_OR, OP_LIT_AND,
                              OP_LIT_XOR};

endmodule : bid_decode

// file: src/bid_alu.sv
// Eight-bit result and flag logic for one decoded operation.
// Assumes operands are settled from the register file in the same cycle.
`timescale 1ns/10ps
module bid_alu
  import bid_pkg::*;
(
  input  bid_op_t          op,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  fval,
  input  wire logic [7:0]  lit,
  input  wire logic [2:0]  bpos,
  input  wire logic        cin,
  output logic [7:0]       res,
  output logic             c_o,
  output logic             dc_o,
  output logic             z_o
);

  logic [8:0] sum;
  logic [4:0] hsum;

  always_comb begin
    sum  = {1'b0, fval} + {1'b0, acc};
    hsum = {1'b0, fval[3:0]} + {1'b0, acc[3:0]};
    res  = fval;
    c_o  = cin;
    dc_o = 1'b0;
    case (op)
      OP_ADD: begin
        res  = sum[7:0];
        c_o  = sum[8];
        dc_o = hsum[4];
      end
      OP_SUB: begin
        // Carry reads as no-borrow
        res  = fval - acc;
        c_o  = fval >= acc;
        dc_o = fval[3:0] >= acc[3:0];
      end
      OP_STORE_ACC:             res = acc;
      OP_ZERO_ACC, OP_ZERO_FILE: res = 8'h00;
      OP_DEC, OP_DECSZ:         res = fval - 8'h01;
      OP_INC, OP_INCSZ:         res = fval + 8'h01;
      OP_OR:                    res = acc | fval;
      OP_AND:                   res = acc & fval;
      OP_XOR:                   res = acc ^ fval;
      OP_INV:                   res = ~fval;
      OP_SWAP:                  res = {fval[3:0], fval[7:4]};
      OP_RR: begin
        res = {cin, fval[7:1]};
        c_o = fval[0];
      end
      OP_RL: begin
        res = {fval[6:0], cin};
        c_o = fval[7];
      end
      OP_BCLR:                  res[bpos] = 1'b0;
      OP_BSET:                  res[bpos] = 1'b1;
      OP_LIT_MOV, OP_RETURN_WITH_LITERAL:     res = lit;
      OP_LIT_OR:                res = acc | lit;
      OP_LIT_AND:               res = acc & lit;
      OP_LIT_XOR:               res = acc ^ lit;
      default:                  res = fval;
    endcase
    z_o = res == 8'h00;
  end

endmodule : bid_alu

// file: src/bid_core.sv
// Instruction sequencer with register file, accumulator, flags and APB.
// Assumes software feeds instruction words through the APB slave.
`timescale 1ns/10ps
module bid_core
  import bid_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_D
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       port_dir,
  output logic             standby,
  output logic             prescaler_clear,
  output logic             watchdog_clear
);

  if (STACK_DEPTH < 1) begin : g_chk
    $error("bid_core needs a stack depth of at least one");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} bid_state_t;

  bid_state_t  state;
  logic [1:0]  qph;
  logic [11:0] instr;
  logic [7:0]  acc;
  logic [7:0]  option_reg;
  logic [2:0]  bank;
  logic [8:0]  pc;
  logic [8:0]  stack [STACK_DEPTH];
  logic [7:0]  rf [128];
  logic        c_f, dc_f, z_f, pd_f, to_f;

  bid_op_t     op;
  logic [4:0]  fsel;
  logic [2:0]  bpos;
  logic [8:0]  lit;
  logic        wr_acc, wr_file, upd_c, upd_dc, upd_z;
  logic [7:0]  res;
  logic        c_o, dc_o, z_o;
  logic [6:0]  fa;
  logic [7:0]  fval;
  logic        exec_fire, take_skip, pcl_wr, pc_chg, busy;
  logic        setup, apb_wr, issue, in_win;
  logic [31:0] next_prdata;

  ////////////////////////////////////////////////////////////////////////////
  bid_decode u_decode (
    .instr   (instr),
    .op      (op),
    .fsel    (fsel),
    .bpos    (bpos),
    .lit     (lit),
    .wr_acc  (wr_acc),
    .wr_file (wr_file),
    .upd_c   (upd_c),
    .upd_dc  (upd_dc),
    .upd_z   (upd_z)
  );

  bid_alu u_alu (
    .op   (op),
    .acc  (acc),
    .fval (fval),
    .lit  (lit[7:0]),
    .bpos (bpos),
    .cin  (c_f),
    .res  (res),
    .c_o  (c_o),
    .dc_o (dc_o),
    .z_o  (z_o)
  );

  // Bank bits extend the five-bit field to the full file space
  assign fa   = {bank[1:0], fsel};
  assign fval = (fa == PCL_ADDR) ? pc[7:0] : rf[fa];

  assign exec_fire = ce && state == ST_EXEC && qph == QPH_LAST;
  assign take_skip = (op inside {OP_DECSZ, OP_INCSZ} && z_o) ||
                     (op == OP_BTSC && !fval[bpos]) ||
                     (op == OP_BTSS && fval[bpos]);
  assign pcl_wr    = wr_file && fa == PCL_ADDR;
  assign pc_chg    = op inside {OP_GOTO, OP_CALL, OP_RETURN_WITH_LITERAL} || pcl_wr;
  assign busy      = state != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_mapped(input logic [11:0] a);
    return a inside {REG_INSTR, REG_ACC, REG_STATUS, REG_PC, REG_AUX} ||
           a[11:9] == FILE_WIN;
  endfunction : addr_mapped

  assign setup  = psel && !penable;
  assign pready = 1'b1;
  // A refused write has pslverr set and never lands
  assign apb_wr = ce && psel && penable && pwrite && !pslverr;
  assign issue  = apb_wr && paddr == REG_INSTR;
  assign in_win = paddr[11:9] == FILE_WIN;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      REG_INSTR:  next_prdata = {20'h00000, instr};
      REG_ACC:    next_prdata = {24'h000000, acc};
      REG_STATUS: next_prdata = {24'h000000, 1'b0, standby, busy, to_f,
                                 pd_f, z_f, dc_f, c_f};
      REG_PC:     next_prdata = {23'h000000, pc};
      REG_AUX:    next_prdata = {13'h0000, bank, option_reg, port_dir};
      default: begin
        if (in_win) next_prdata = {24'h000000, rf[paddr[8:2]]};
      end
    endcase
  end

  // Read data and error are taken in the setup cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= next_prdata;
      pslverr <= !addr_mapped(paddr) ||
                 (pwrite && paddr inside {REG_INSTR, REG_PC} &&
                  (busy || standby));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      qph   <= 2'h0;
      instr <= 12'h000;
    end else if (ce) begin
      if (issue) begin
        instr <= pwdata[11:0];
        state <= ST_EXEC;
        qph   <= 2'h0;
      end else if (busy) begin
        qph <= qph + 2'h1;
        if (qph == QPH_LAST) begin
          qph <= 2'h0;
          // Flush slot stands for the discarded prefetch
          state <= (state == ST_EXEC && (take_skip || pc_chg)) ?
                   ST_FLUSH : ST_IDLE;
        end
      end
    end
  end

  // Hardware updates come last so they win over a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RST;
    end else if (ce) begin
      if (apb_wr && paddr == REG_ACC) acc <= pwdata[7:0];
      if (exec_fire && wr_acc) acc <= res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_f     <= 1'b0;
      dc_f    <= 1'b0;
      z_f     <= 1'b0;
      pd_f    <= 1'b1;
      to_f    <= 1'b1;
      standby <= 1'b0;
    end else if (ce) begin
      if (apb_wr && paddr == REG_STATUS) begin
        c_f  <= pwdata[STB_C];
        dc_f <= pwdata[STB_DC];
        z_f  <= pwdata[STB_Z];
        if (pwdata[STB_WAKE]) standby <= 1'b0;
      end
      if (exec_fire) begin
        if (upd_c) c_f <= c_o;
        if (upd_dc) dc_f <= dc_o;
        if (upd_z) z_f <= z_o;
        if (op == OP_SLEEP) begin
          pd_f    <= 1'b0;
          to_f    <= 1'b1;
          standby <= 1'b1;
        end
        if (op == OP_WDT) begin
          pd_f <= 1'b1;
          to_f <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_RST;
      for (int i = 0; i < STACK_DEPTH; i++) stack[i] <= PC_RST;
    end else if (ce) begin
      if (apb_wr && paddr == REG_PC) pc <= pwdata[8:0];
      if (exec_fire) begin
        if (op == OP_GOTO) begin
          pc <= lit;
        end else if (op == OP_CALL) begin
          pc <= {1'b0, lit[7:0]};
          for (int i = STACK_DEPTH - 1; i > 0; i--) stack[i] <= stack[i-1];
          stack[0] <= pc + 9'h001;
        end else if (op == OP_RETURN_WITH_LITERAL) begin
          pc <= stack[0];
          for (int i = 0; i < STACK_DEPTH - 1; i++) stack[i] <= stack[i+1];
        end else if (pcl_wr) begin
          pc <= {1'b0, res};
        end else if (take_skip) begin
          pc <= pc + 9'h002;
        end else begin
          pc <= pc + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) rf[i] <= 8'h00;
    end else if (ce) begin
      if (apb_wr && in_win) rf[paddr[8:2]] <= pwdata[7:0];
      if (exec_fire && wr_file) rf[fa] <= res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg      <= OPT_RST;
      port_dir        <= PDIR_RST;
      bank            <= BANK_RST;
      prescaler_clear <= 1'b0;
      watchdog_clear  <= 1'b0;
    end else if (ce) begin
      prescaler_clear <= exec_fire && wr_file && fa == TMR_ADDR &&
                         !option_reg[OPT_PSA];
      watchdog_clear  <= exec_fire && op inside {OP_WDT, OP_SLEEP};
      if (exec_fire) begin
        if (op == OP_OPTION) option_reg <= acc;
        if (op == OP_BANK) bank <= lit[2:0];
        // A one in the latch floats the pin
        if (op == OP_PORTDIR && fsel[2:0] == PORT_DIR_SEL)
          port_dir <= acc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
    exec_fire && wr_acc |=> acc == $past(res))
    else $error("accumulator missed its result");

  a_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
    exec_fire && wr_file |=> rf[$past(fa)] == $past(res) && acc ==
    $past(acc))
    else $error("file result misrouted");

  a_four_periods: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state == ST_EXEC && qph == 2'h0 && ce) ##1 ce [*3] |-> exec_fire)
    else $error("instruction cycle not four clocks");

  a_skip_flush: assert property (@(posedge pclk)
    disable iff (!presetn)
    exec_fire && (take_skip || pc_chg) |=> state == ST_FLUSH ##4
    state == ST_IDLE || !ce)
    else $error("skip or jump did not take two cycles");

  a_single_cycle: assert property (@(posedge pclk)
    disable iff (!presetn)
    exec_fire && !take_skip && !pc_chg |=> state == ST_IDLE &&
    pc == $past(pc) + 9'h001)
    else $error("plain instruction not one cycle");

  a_count_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    exec_fire && op inside {OP_DECSZ, OP_INCSZ} &&
    !(apb_wr && paddr == REG_STATUS) |=>
    {c_f, dc_f, z_f} == $past({c_f, dc_f, z_f}))
    else $error("count-and-skip changed a flag");

  a_call_bit9: assert property (@(posedge pclk)
    disable iff (!presetn)
    exec_fire && op == OP_CALL |=> pc == {1'b0, $past(lit[7:0])})
    else $error("call left program counter bit nine set");

  a_port_dir: assert property (@(posedge pclk) disable iff (!presetn)
    exec_fire && op == OP_PORTDIR && fsel[2:0] == PORT_DIR_SEL |=>
    port_dir == $past(acc))
    else $error("direction latches not loaded");

  a_presc_clr: assert property (@(posedge pclk)
    disable iff (!presetn)
    prescaler_clear |-> $past(exec_fire && wr_file && fa == TMR_ADDR))
    else $error("spurious prescaler clear");

  a_sleep_bits: assert property (@(posedge pclk)
    disable iff (!presetn)
    exec_fire && op == OP_SLEEP |=> standby && !pd_f && to_f &&
    watchdog_clear)
    else $error("standby entry bits wrong");

endmodule : bid_core

// file: verification/bid_prog_mem.sv
// Program memory model holding a short call, return and branch routine.
// Assumes the bench presents the program counter and fetches one word.
`timescale 1ns/10ps
module bid_prog_mem
  import bid_pkg::*;
(
  input  wire logic [8:0]  addr,
  output logic      [11:0] word
);
  // Unlisted addresses read as no-op words
  always_comb begin
    case (addr)
      9'h0F0:  word = 12'h904;
      9'h004:  word = 12'h8A5;
      9'h0F1:  word = 12'hBFF;
      default: word = 12'h000;
    endcase
  end
endmodule : bid_prog_mem

// file: verification/testbench.sv
// Self-checking bench: APB master, instruction table, control flow.
// Assumes bid_core and the program memory model beside this file.
`timescale 1ns/10ps
module testbench
  import bid_pkg::*;
;
  typedef struct packed {
    logic [11:0] w;
    logic [7:0]  acc;
    logic [7:0]  fv;
    logic [2:0]  fl;
    logic        two;
  } bid_step_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        standby, prescaler_clear, watchdog_clear, ce;
  logic [11:0] paddr, word;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  port_dir;
  logic [8:0]  pc_exp, fpc;
  int          fails = 0, compares = 0, cyc = 0, wd_n = 0, ps_n = 0;
  logic [8:0]  flow_pc [3] = '{9'h004, 9'h0F1, 9'h1FF};
  bid_step_t   steps [24] = '{
    {12'hC5A, 8'h5A, 8'h00, 3'h0, 1'b0},
    {12'h025, 8'h5A, 8'h5A, 3'h0, 1'b0},
    {12'hE0F, 8'h0A, 8'h5A, 3'h0, 1'b0},
    {12'hF0A, 8'h00, 8'h5A, 3'h4, 1'b0},
    {12'hC03, 8'h03, 8'h5A, 3'h4, 1'b0},
    {12'hD00, 8'h03, 8'h5A, 3'h0, 1'b0},
    {12'h1C5, 8'h5D, 8'h5A, 3'h0, 1'b0},
    {12'h1E5, 8'h5D, 8'hB7, 3'h2, 1'b0},
    {12'h165, 8'h5D, 8'h15, 3'h2, 1'b0},
    {12'h185, 8'h48, 8'h15, 3'h2, 1'b0},
    {12'h125, 8'h48, 8'h5D, 3'h2, 1'b0},
    {12'h325, 8'h48, 8'h2E, 3'h3, 1'b0},
    {12'h365, 8'h48, 8'h5D, 3'h2, 1'b0},
    {12'h405, 8'h48, 8'h5C, 3'h2, 1'b0},
    {12'h5E5, 8'h48, 8'hDC, 3'h2, 1'b0},
    {12'h7E5, 8'h48, 8'hDC, 3'h2, 1'b1},
    {12'h605, 8'h48, 8'hDC, 3'h2, 1'b1},
    {12'h6E5, 8'h48, 8'hDC, 3'h2, 1'b0},
    {12'h065, 8'h48, 8'h00, 3'h6, 1'b0},
    {12'h3E5, 8'h48, 8'h01, 3'h6, 1'b0},
    {12'h2E5, 8'h48, 8'h00, 3'h6, 1'b1},
    {12'h245, 8'hFF, 8'h00, 3'h2, 1'b0},
    {12'h085, 8'h01, 8'h00, 3'h0, 1'b0},
    {12'h040, 8'h00, 8'h00, 3'h4, 1'b0}
  };

  bid_core u_bid_core (
    .pclk            (pclk),
    .presetn         (presetn),
    .ce              (ce),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .port_dir        (port_dir),
    .standby         (standby),
    .prescaler_clear (prescaler_clear),
    .watchdog_clear  (watchdog_clear)
  );
  bid_prog_mem u_bid_prog_mem (.addr(fpc), .word(word));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Pulses last one cycle, so they are tallied rather than polled
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (watchdog_clear === 1'b1) wd_n <= wd_n + 1;
    if (prescaler_clear === 1'b1) ps_n <= ps_n + 1;
    if (cyc == 8000) begin
      fails++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk

  // Busy is polled; elapsed cycles separate one and two instruction cycles
  task automatic exec(input logic [11:0] w, input logic two);
    int t0;
    apb(1'b1, REG_INSTR, {20'h0, w});
    chk("instr_err", 32'h0, {31'h0, er});
    t0 = cyc;
    rd = 32'h20;
    for (int i = 0; i < 20 && rd[STB_BUSY] !== 1'b0; i++)
      apb(1'b0, REG_STATUS, 32'h0);
    chk("busy", 32'h0, {31'h0, rd[STB_BUSY]});
    chk("slow", {31'h0, two}, {31'h0, (cyc - t0) >= 9});
  endtask : exec

  //////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pc_exp = 9'h000;
    fpc = 9'h000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("acc_rst", REG_ACC, 32'h0);
    rchk("stat_rst", REG_STATUS, 32'h18);
    rchk("aux_rst", REG_AUX, 32'h0000FFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("done reset");
    foreach (steps[i]) begin
      exec(steps[i].w, steps[i].two);
      pc_exp = pc_exp + (steps[i].two ? 9'h2 : 9'h1);
      rchk("acc", REG_ACC, {24'h0, steps[i].acc});
      rchk("file5", 12'h214, {24'h0, steps[i].fv});
      apb(1'b0, REG_STATUS, 32'h0);
      chk("flags", {29'h0, steps[i].fl}, {29'h0, rd[2:0]});
      rchk("pc", REG_PC, {23'h0, pc_exp});
    end
    $display("done table");
    apb(1'b1, REG_PC, 32'hF0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, REG_PC, 32'h0);
      fpc = rd[8:0];
      @(negedge pclk);
      exec(word, 1'b1);
      rchk("flow_pc", REG_PC, {23'h0, flow_pc[i]});
    end
    rchk("ret_acc", REG_ACC, 32'hA5);
    apb(1'b1, REG_PC, 32'h150);
    apb(1'b1, REG_ACC, 32'h34);
    exec(12'h022, 1'b1);
    rchk("pc_bit9", REG_PC, 32'h034);
    $display("done flow");
    apb(1'b1, REG_ACC, 32'h3C);
    exec(12'h005, 1'b0);
    chk("dir_f5", 32'hFF, {24'h0, port_dir});
    exec(12'h006, 1'b0);
    chk("dir_f6", 32'h3C, {24'h0, port_dir});
    exec(12'h021, 1'b0);
    chk("psc_off", 32'h0, ps_n);
    apb(1'b1, REG_ACC, 32'hF7);
    exec(12'h002, 1'b0);
    rchk("aux_opt", REG_AUX, 32'h0000F73C);
    exec(12'h021, 1'b0);
    chk("psc_on", 32'h1, ps_n);
    exec(12'h012, 1'b0);
    exec(12'h025, 1'b0);
    rchk("aux_bank", REG_AUX, 32'h0002F73C);
    rchk("file45", 12'h314, 32'hF7);
    rchk("file05", 12'h214, 32'h00);
    $display("done control");
    // Held enable: the write must not land
    ce <= 1'b0;
    apb(1'b1, REG_ACC, 32'h99);
    ce <= 1'b1;
    rchk("ce_hold", REG_ACC, 32'hF7);
    exec(12'h003, 1'b0);
    chk("standby", 32'h1, {31'h0, standby});
    rchk("stat_sb", REG_STATUS, 32'h54);
    chk("wdc_sb", 32'h1, wd_n);
    apb(1'b1, REG_INSTR, 32'h0);
    chk("instr_sb", 32'h1, {31'h0, er});
    apb(1'b1, REG_STATUS, 32'h84);
    // Wake lands at the access edge; look once it has settled
    @(negedge pclk);
    chk("wake", 32'h0, {31'h0, standby});
    exec(12'h004, 1'b0);
    rchk("stat_wd", REG_STATUS, 32'h1C);
    chk("wdc_wd", 32'h2, wd_n);
    $display("done standby");
    close_out();
  end
endmodule : testbench
